// ### verilog/gdp_pkg.sv
// Package for the primary-side pin block of the isolated gate driver.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
package gdp_pkg;
	localparam int  CLK_PERIOD_NS      = 8;
	localparam int  SYNC_STAGES        = 2;
	// Dead time added after the monitor input falls
	localparam int  DEAD_TIME_NS       = 200;
	localparam int  DEAD_TIME_CYCLES   =
		(DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  DEAD_CNT_W         = 8;
	// Reset pulse must be stable this long to count as valid
	localparam int  RST_VALID_NS       = 80;
	localparam int  RST_VALID_CYCLES   =
		(RST_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  RST_CNT_W          = 8;
	localparam logic [7:0] DEAD_CNT_RST = 8'h00;

	// Value a pin reads when the driver leaves it floating
	localparam logic PULL_PWM  = 1'b0;
	localparam logic PULL_STP  = 1'b0;
	localparam logic PULL_EN   = 1'b0;
	localparam logic PULL_SCLK = 1'b1;
	localparam logic PULL_SDI  = 1'b1;
	localparam logic PULL_CS   = 1'b1;
	localparam logic PULL_TRIG = 1'b0;
	localparam logic PULL_DIO  = 1'b0;

	typedef struct packed {
		logic pwm;
		logic stp;
		logic en;
		logic rst_n;
		logic trig;
	} gdp_sync_t;

	typedef enum logic [1:0] {
		GDP_ST_NOT_READY,
		GDP_ST_READY
	} gdp_state_t;

	typedef struct packed {
		gdp_state_t           st;
		logic                 pwm_cmd;
		logic                 pwm_prev;
		logic                 inhibit;
		logic [DEAD_CNT_W-1:0] dead_cnt;
		logic [RST_CNT_W-1:0]  rst_cnt;
		logic                 flt_a_oe_n;
		logic                 flt_b_oe_n;
		logic                 rdy_oe_n;
		logic                 dio_out;
		logic                 dio_oe_n;
		logic                 dio_in;
		logic                 sdo;
		logic                 trig_prev;
		logic                 trig_pulse;
		logic                 sclk;
		logic                 sdi;
		logic                 cs_n;
	} gdp_regs_t;
endpackage : gdp_pkg

// ### verilog/gdp_sync.sv
// Two-flop synchroniser bank for the primary-side inputs.
// Assumes inputs may change at any time relative to mclk.
`timescale 1ns/100ps
`default_nettype none
module gdp_sync
	import gdp_pkg::*;
#(
	parameter int               WIDTH   = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	genvar i;
	// Each lane resets to its floating level, a constant per lane
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					meta_q[i] <= RST_VAL[i];
					q[i]      <= RST_VAL[i];
				end else begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : gdp_sync
`default_nettype wire

// ### verilog/gdp_pins.sv
// Primary-side pin logic of the isolated gate driver.
// Assumes floating pins arrive with pin_valid low; outputs via enables.
// What this block does
// R1 - PWM on/off alone on one-way channel
// R2 - Other traffic on separate two-way channel
// R3 - PWM non-inverting, floating reads low
// R4 - Monitor input is complementary PWM, floats low
// R5 - Enable low turns device off, floats low
// R6 - Class A failure pulls fault A low
// R7 - Class B failure pulls fault B low
// R8 - Chip select low-active, floats high
// R9 - Valid reset pulse restores default state
// R10 - Ready pin released only while functional
// R11 - Digital pin input or push-pull output
// R12 - Conversion trigger floats low, no trigger
// R13 - SPI data output is push-pull
// R14 - SPI clock and data float high
// R15 - On when PWM high with enable valid
// R16 - Enable invalid forces off commands
// R17 - Monitor plus dead time blocks rising edges
// R18 - Synchronise control inputs before use
`timescale 1ns/100ps
`default_nettype none
module gdp_pins
	import gdp_pkg::*;
#(
	parameter int DEAD_CYCLES = DEAD_TIME_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       pwm_in,
	input  wire logic       pwm_in_valid,
	input  wire logic       shoot_through_monitor_in,
	input  wire logic       stp_in_valid,
	input  wire logic       enable_in,
	input  wire logic       enable_in_valid,
	input  wire logic       conversion_trigger_in,
	input  wire logic       trig_in_valid,
	input  wire logic       sclk_in,
	input  wire logic       sclk_in_valid,
	input  wire logic       sdi_in,
	input  wire logic       sdi_in_valid,
	input  wire logic       chip_select_n,
	input  wire logic       cs_in_valid,
	input  wire logic       reset_in_ready_in_n,
	input  wire logic       primary_digital_channel_i,
	input  wire logic       dio_in_valid,
	input  wire logic       dio_out_mode,
	input  wire logic       dio_out_val,
	input  wire logic       spi_sdo_val,
	input  wire logic       chip_functional,
	input  wire logic       fail_class_a,
	input  wire logic       fail_class_b,
	input  wire logic       link_tx_data,
	output logic            pwm_link_cmd,
	output logic            data_link_tx,
	output logic            fault_class_a_out_n,
	output logic            fault_class_a_oe_n,
	output logic            fault_class_b_out_n,
	output logic            fault_class_b_oe_n,
	output logic            reset_in_ready_out_n,
	output logic            reset_ready_oe_n,
	output logic            primary_digital_channel_o,
	output logic            primary_digital_channel_oe_n,
	output logic            dio_rx,
	output logic            spi_sdo,
	output logic            spi_sclk,
	output logic            spi_sdi,
	output logic            spi_cs_n,
	output logic            conversion_trigger_pulse,
	output logic            soft_reset_q
);
	////////////////////////////////////////////////////////////////////
	// Floating pins resolve to their pull level
	function automatic logic pull(input logic v, input logic ok,
		input logic lvl);
		pull = ok ? v : lvl;
	endfunction : pull

	gdp_sync_t sync_d;
	gdp_sync_t sync_q;
	gdp_regs_t r_q;
	gdp_regs_t r_d;
	logic      srst_q;

	always_comb begin
		sync_d.pwm   = pull(pwm_in, pwm_in_valid, PULL_PWM);          // [R3]
		sync_d.stp   = pull(shoot_through_monitor_in, stp_in_valid,
			PULL_STP);                                                // [R4]
		sync_d.en    = pull(enable_in, enable_in_valid, PULL_EN);     // [R5]
		sync_d.rst_n = reset_in_ready_in_n;
		sync_d.trig  = pull(conversion_trigger_in, trig_in_valid,
			PULL_TRIG);                                               // [R12]
	end

	// Bit 1 is the reset pin, which idles high
	gdp_sync #(
		.WIDTH   (5),
		.RST_VAL (5'h02)
	) u_sync (
		.mclk    (mclk),
		.resetn  (resetn),
		.d       (sync_d),                                           // [R18]
		.q       (sync_q)
	);

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		r_d = r_q;
		// Disabled PWM counts as low: re-enable with PWM high turns on
		r_d.pwm_prev   = sync_q.pwm & sync_q.en;
		r_d.trig_prev  = sync_q.trig;
		r_d.trig_pulse = sync_q.trig & ~r_q.trig_prev;               // [R12]
		// Inhibit window: monitor high, then count dead time
		if (sync_q.stp) begin
			r_d.inhibit  = 1'b1;                                      // [R17]
			r_d.dead_cnt = DEAD_CNT_W'(DEAD_CYCLES);
		end else if (r_q.dead_cnt != '0) begin
			r_d.dead_cnt = r_q.dead_cnt - 1'b1;
			r_d.inhibit  = (r_q.dead_cnt != 8'h01);
		end else begin
			r_d.inhibit = 1'b0;
		end
		// Off always wins; on only from a clean rising edge
		if (!sync_q.en || !sync_q.pwm) begin
			r_d.pwm_cmd = 1'b0;                                       // [R15] [R16]
		end else if (sync_q.pwm && !r_q.pwm_prev) begin
			r_d.pwm_cmd = !(r_q.inhibit || sync_q.stp);               // [R17]
		end
		// Reset counter: low must persist to count as a valid pulse
		// Own pull-low reads back; host reset unseen while not ready
		if (!sync_q.rst_n && r_q.rdy_oe_n) begin
			if (r_q.rst_cnt != RST_CNT_W'(RST_VALID_CYCLES))
				r_d.rst_cnt = r_q.rst_cnt + 1'b1;
		end else begin
			r_d.rst_cnt = '0;
		end
		case (r_q.st)
			GDP_ST_NOT_READY: begin
				if (chip_functional)
					r_d.st = GDP_ST_READY;
			end
			GDP_ST_READY: begin
				if (!chip_functional)
					r_d.st = GDP_ST_NOT_READY;
			end
			default: r_d.st = GDP_ST_NOT_READY;
		endcase
		// Released only while ready; never driven high
		r_d.rdy_oe_n   = (r_d.st == GDP_ST_READY);                    // [R10]
		r_d.flt_a_oe_n = ~fail_class_a;                               // [R6]
		r_d.flt_b_oe_n = ~fail_class_b;                               // [R7]
		r_d.dio_oe_n   = ~dio_out_mode;                               // [R11]
		r_d.dio_out    = dio_out_val;
		r_d.dio_in     = dio_out_mode ? 1'b0 :
			pull(primary_digital_channel_i, dio_in_valid, PULL_DIO);  // [R11]
		r_d.sdo        = spi_sdo_val;                                 // [R13]
		r_d.sclk       = pull(sclk_in, sclk_in_valid, PULL_SCLK);     // [R14]
		r_d.sdi        = pull(sdi_in, sdi_in_valid, PULL_SDI);        // [R14]
		r_d.cs_n       = pull(chip_select_n, cs_in_valid, PULL_CS);   // [R8]
		// Valid reset pulse clears command, inhibit and dead time, and drops to not ready
		if (r_q.rst_cnt == RST_CNT_W'(RST_VALID_CYCLES)) begin
			r_d.pwm_cmd  = 1'b0;                                      // [R9]
			r_d.inhibit  = 1'b0;
			r_d.dead_cnt = DEAD_CNT_RST;
			r_d.st       = GDP_ST_NOT_READY;
			r_d.rdy_oe_n = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r_q          <= '0;
			r_q.st       <= GDP_ST_NOT_READY;
			r_q.flt_a_oe_n <= 1'b1;
			r_q.flt_b_oe_n <= 1'b1;
			r_q.dio_oe_n <= 1'b1;
			r_q.sclk     <= 1'b1;
			r_q.sdi      <= 1'b1;
			r_q.cs_n     <= 1'b1;
			srst_q       <= 1'b0;
		end else begin
			r_q          <= r_d;
			srst_q       <= (r_q.rst_cnt == RST_CNT_W'(RST_VALID_CYCLES));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Separate registered channels: PWM only, then everything else
	logic data_tx_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			data_tx_q <= 1'b0;
		else
			data_tx_q <= link_tx_data;                                // [R2]
	end

	assign pwm_link_cmd                 = r_q.pwm_cmd;                 // [R1]
	assign data_link_tx                 = data_tx_q;
	assign fault_class_a_out_n          = 1'b0;
	assign fault_class_a_oe_n           = r_q.flt_a_oe_n;
	assign fault_class_b_out_n          = 1'b0;
	assign fault_class_b_oe_n           = r_q.flt_b_oe_n;
	assign reset_in_ready_out_n         = 1'b0;
	assign reset_ready_oe_n             = r_q.rdy_oe_n;
	assign primary_digital_channel_o    = r_q.dio_out;
	assign primary_digital_channel_oe_n = r_q.dio_oe_n;
	assign dio_rx                       = r_q.dio_in;
	assign spi_sdo                      = r_q.sdo;
	assign spi_sclk                     = r_q.sclk;
	assign spi_sdi                      = r_q.sdi;
	assign spi_cs_n                     = r_q.cs_n;
	assign conversion_trigger_pulse     = r_q.trig_pulse;
	assign soft_reset_q                 = srst_q;

	////////////////////////////////////////////////////////////////////
	a_off_when_disabled: assert property (                  // [R16]
		@(posedge mclk) disable iff (!resetn)
		!sync_q.en |=> !pwm_link_cmd)
		else $error("PWM on while enable invalid");
	a_off_when_low: assert property (                       // [R15]
		@(posedge mclk) disable iff (!resetn)
		!sync_q.pwm |=> !pwm_link_cmd)
		else $error("PWM on while input low");
	a_on_when_clean: assert property (                      // [R15]
		@(posedge mclk) disable iff (!resetn)
		(sync_q.pwm && !r_q.pwm_prev && sync_q.en && !sync_q.stp &&
		 !r_q.inhibit && r_q.rst_cnt != RST_CNT_W'(RST_VALID_CYCLES))
		|=> pwm_link_cmd)
		else $error("Clean rising edge did not turn on");
	a_inhibit_edge: assert property (                       // [R17]
		@(posedge mclk) disable iff (!resetn)
		(sync_q.stp && !r_q.pwm_cmd) |=> !pwm_link_cmd)
		else $error("Rising edge passed during inhibit");
	a_stay_on: assert property (                            // [R17]
		@(posedge mclk) disable iff (!resetn)
		(pwm_link_cmd && sync_q.pwm && sync_q.en && sync_q.stp &&
		 r_q.rst_cnt != RST_CNT_W'(RST_VALID_CYCLES)) |=> pwm_link_cmd)
		else $error("Inhibit forced output off");
	a_fault_a: assert property (                            // [R6]
		@(posedge mclk) disable iff (!resetn)
		fail_class_a |=> !fault_class_a_oe_n && !fault_class_a_out_n)
		else $error("Fault A not pulled low");
	a_fault_b: assert property (                            // [R7]
		@(posedge mclk) disable iff (!resetn)
		fail_class_b |=> !fault_class_b_oe_n)
		else $error("Fault B not pulled low");
	a_ready_release: assert property (                      // [R10]
		@(posedge mclk) disable iff (!resetn)
		!chip_functional |=> !reset_ready_oe_n)
		else $error("Ready released while not functional");
	a_reset_clears: assert property (                       // [R9]
		@(posedge mclk) disable iff (!resetn)
		r_q.rst_cnt == RST_CNT_W'(RST_VALID_CYCLES) |=> !pwm_link_cmd)
		else $error("Valid reset did not clear command");
	a_cs_float: assert property (                           // [R8]
		@(posedge mclk) disable iff (!resetn)
		!cs_in_valid |=> spi_cs_n)
		else $error("Floating chip select not high");
	a_sdi_float: assert property (                          // [R14]
		@(posedge mclk) disable iff (!resetn)
		!sdi_in_valid && !sclk_in_valid |=> spi_sdi && spi_sclk)
		else $error("Floating SPI inputs not high");
	a_dio_push: assert property (                           // [R11]
		@(posedge mclk) disable iff (!resetn)
		dio_out_mode |=> !primary_digital_channel_oe_n &&
		primary_digital_channel_o == $past(dio_out_val))
		else $error("Digital pin not driven in output mode");
	a_trig_single: assert property (                        // [R12]
		@(posedge mclk) disable iff (!resetn)
		conversion_trigger_pulse |=> !conversion_trigger_pulse)
		else $error("Trigger pulse longer than one cycle");
	a_trig_quiet: assert property (                         // [R12]
		@(posedge mclk) disable iff (!resetn)
		!sync_q.trig |=> !conversion_trigger_pulse)
		else $error("Trigger pulse without trigger input");
	a_dio_input: assert property (                          // [R11]
		@(posedge mclk) disable iff (!resetn)
		!dio_out_mode |=> primary_digital_channel_oe_n)
		else $error("Digital pin driven in input mode");
	a_dio_float: assert property (                          // [R11]
		@(posedge mclk) disable iff (!resetn)
		(!dio_out_mode && !dio_in_valid) |=> !dio_rx)
		else $error("Floating digital pin not read low");
	a_dio_read: assert property (                           // [R11]
		@(posedge mclk) disable iff (!resetn)
		(!dio_out_mode && dio_in_valid) |=>
		dio_rx == $past(primary_digital_channel_i))
		else $error("Digital pin input not followed");
	a_sdo_follow: assert property (                         // [R13]
		@(posedge mclk) disable iff (!resetn)
		1'b1 |=> spi_sdo == $past(spi_sdo_val))
		else $error("SPI data output not driven");
	a_link_follow: assert property (                        // [R2]
		@(posedge mclk) disable iff (!resetn)
		1'b1 |=> data_link_tx == $past(link_tx_data))
		else $error("Two-way channel data not passed");
	a_pwm_only: assert property (                           // [R1]
		@(posedge mclk) disable iff (!resetn)
		pwm_link_cmd |-> $past(sync_q.pwm) && $past(sync_q.en))
		else $error("PWM channel on without enabled PWM");
	a_reset_ready: assert property (                        // [R9]
		@(posedge mclk) disable iff (!resetn)
		r_q.rst_cnt == RST_CNT_W'(RST_VALID_CYCLES) |=> !reset_ready_oe_n)
		else $error("Valid reset left ready released");
	a_soft_reset: assert property (                         // [R9]
		@(posedge mclk) disable iff (!resetn)
		r_q.rst_cnt == RST_CNT_W'(RST_VALID_CYCLES) |=> soft_reset_q)
		else $error("Valid reset not flagged");
	a_dead_edge: assert property (                          // [R17]
		@(posedge mclk) disable iff (!resetn)
		($fell(sync_q.stp) && !r_q.pwm_cmd) |=> !pwm_link_cmd)
		else $error("Rising edge passed in dead time");
	a_sclk_float: assert property (                         // [R14]
		@(posedge mclk) disable iff (!resetn)
		!sclk_in_valid |=> spi_sclk)
		else $error("Floating SPI clock not high");
	a_cs_driven: assert property (                          // [R8]
		@(posedge mclk) disable iff (!resetn)
		cs_in_valid |=> spi_cs_n == $past(chip_select_n))
		else $error("Driven chip select not followed");
	a_sdi_driven: assert property (                         // [R14]
		@(posedge mclk) disable iff (!resetn)
		sdi_in_valid |=> spi_sdi == $past(sdi_in))
		else $error("Driven SPI data input not followed");
endmodule : gdp_pins
`default_nettype wire

// ### tb/gdp_host_model.sv
// Host model: drives the control pins of the primary-side pin block.
// Assumes the bench sets levels in lvl; a low bit in drv floats a pin.
`timescale 1ns/100ps
`default_nettype none
module gdp_host_model
	import gdp_pkg::*;
(
	input  wire logic      reset_ready_oe_n,
	input  wire gdp_sync_t lvl,
	input  wire gdp_sync_t drv,
	output logic           pwm_in,
	output logic           pwm_in_valid,
	output logic           shoot_through_monitor_in,
	output logic           stp_in_valid,
	output logic           enable_in,
	output logic           enable_in_valid,
	output logic           conversion_trigger_in,
	output logic           trig_in_valid,
	output logic           reset_in_ready_in_n
);
	////////////////////////////////////////////////////////////////////////
	// Floating pin shows the opposite of its pull, so only valid tells
	always_comb begin
		pwm_in                   = drv.pwm ? lvl.pwm : ~PULL_PWM;
		pwm_in_valid             = drv.pwm;
		shoot_through_monitor_in = drv.stp ? lvl.stp : ~PULL_STP;
		stp_in_valid             = drv.stp;
		enable_in                = drv.en ? lvl.en : ~PULL_EN;
		enable_in_valid          = drv.en;
		conversion_trigger_in    = drv.trig ? lvl.trig : ~PULL_TRIG;
		trig_in_valid            = drv.trig;
		// Open drain with pull-up: either party may pull it low
		reset_in_ready_in_n      =
			~((drv.rst_n & ~lvl.rst_n) | ~reset_ready_oe_n);
	end
endmodule : gdp_host_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the primary-side pin block.
// Assumes the host model drives the control pins; inputs move 1 ns late.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import gdp_pkg::*;
	// Short dead time keeps the inhibit scenario brief
	localparam int DC = 6;
	logic mclk = 1'b0, resetn = 1'b0;
	gdp_sync_t lvl, drv;
	logic pwm_in, pwm_in_valid, shoot_through_monitor_in, stp_in_valid;
	logic enable_in, enable_in_valid, conversion_trigger_in, trig_in_valid;
	logic reset_in_ready_in_n, sclk_in, sclk_in_valid, sdi_in, sdi_in_valid;
	logic chip_select_n, cs_in_valid, primary_digital_channel_i;
	logic dio_in_valid, dio_out_mode, dio_out_val, spi_sdo_val;
	logic chip_functional, fail_class_a, fail_class_b, link_tx_data;
	logic pwm_link_cmd, data_link_tx, fault_class_a_out_n;
	logic fault_class_a_oe_n, fault_class_b_out_n, fault_class_b_oe_n;
	logic reset_in_ready_out_n, reset_ready_oe_n, primary_digital_channel_o;
	logic primary_digital_channel_oe_n, dio_rx, spi_sdo, spi_sclk, spi_sdi;
	logic spi_cs_n, conversion_trigger_pulse, soft_reset_q, dio_h, dio_hv;
	logic p, e, a, b;
	int n_mismatch = 0, n_tests = 0, n_pulse = 0, n_srst = 0;

	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		n_pulse += (conversion_trigger_pulse === 1'b1);
		n_srst  += (soft_reset_q === 1'b1);
	end
	// Pin wire: the block's driver wins while its enable is low
	assign primary_digital_channel_i = !primary_digital_channel_oe_n ?
		primary_digital_channel_o : dio_h;
	assign dio_in_valid = !primary_digital_channel_oe_n | dio_hv;

	gdp_host_model gdp_host_model_inst (.reset_ready_oe_n, .lvl, .drv,
		.pwm_in, .pwm_in_valid, .shoot_through_monitor_in, .stp_in_valid,
		.enable_in, .enable_in_valid, .conversion_trigger_in,
		.trig_in_valid, .reset_in_ready_in_n);
	gdp_pins #(.DEAD_CYCLES(DC)) gdp_pins_inst (.mclk, .resetn, .pwm_in,
		.pwm_in_valid, .shoot_through_monitor_in, .stp_in_valid, .enable_in,
		.enable_in_valid, .conversion_trigger_in, .trig_in_valid, .sclk_in,
		.sclk_in_valid, .sdi_in, .sdi_in_valid, .chip_select_n, .cs_in_valid,
		.reset_in_ready_in_n, .primary_digital_channel_i, .dio_in_valid,
		.dio_out_mode, .dio_out_val, .spi_sdo_val, .chip_functional,
		.fail_class_a, .fail_class_b, .link_tx_data, .pwm_link_cmd,
		.data_link_tx, .fault_class_a_out_n, .fault_class_a_oe_n,
		.fault_class_b_out_n, .fault_class_b_oe_n, .reset_in_ready_out_n,
		.reset_ready_oe_n, .primary_digital_channel_o,
		.primary_digital_channel_oe_n, .dio_rx, .spi_sdo, .spi_sclk,
		.spi_sdi, .spi_cs_n, .conversion_trigger_pulse, .soft_reset_q);

	////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task check(input string nm, input logic exp, input logic seen);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask : check

	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// Bounded wait for the ready pin to be released
	task wait_rdy;
		for (int i = 0; i < 60 && reset_ready_oe_n !== 1'b1; i++)
			tick(1);
		check("ready_release", 1'b1, reset_ready_oe_n);
		if (reset_ready_oe_n !== 1'b1)
			conclude();
	endtask : wait_rdy

	function logic exp_cmd(input logic pwm, input logic en);
		return pwm & en;
	endfunction : exp_cmd

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h5d6499e6));
		lvl = '{pwm: 1'b0, stp: 1'b0, en: 1'b1, rst_n: 1'b1, trig: 1'b0};
		drv = '1;
		{sclk_in, sdi_in, chip_select_n} = 3'h7;
		{sclk_in_valid, sdi_in_valid, cs_in_valid, dio_hv} = 4'hf;
		{dio_h, dio_out_mode, dio_out_val, spi_sdo_val} = 4'h0;
		{fail_class_a, fail_class_b, link_tx_data} = 3'h0;
		chip_functional = 1'b1;
		tick(20);
		check("rst_cmd", 1'b0, pwm_link_cmd);
		check("rst_flt_a", 1'b1, fault_class_a_oe_n);
		check("rst_rdy", 1'b0, reset_ready_oe_n);
		resetn = 1'b1;
		wait_rdy();
		for (int i = 0; i < 40; i++) begin
			{p, e, a, b} = 4'($urandom);
			if (i < 2)
				{p, e} = {1'b1, i[0]};
			{lvl.pwm, lvl.en, fail_class_a, fail_class_b} = {p, e, a, b};
			{link_tx_data, spi_sdo_val} = {~a, b};
			tick(4);
			check("pwm_cmd", exp_cmd(p, e), pwm_link_cmd);
			check("link_tx", ~a, data_link_tx);
			check("flt_a_oe", ~a, fault_class_a_oe_n);
			check("flt_b_oe", ~b, fault_class_b_oe_n);
			check("flt_a_lvl", 1'b0, fault_class_a_out_n);
			check("flt_b_lvl", 1'b0, fault_class_b_out_n);
			check("sdo", b, spi_sdo);
		end
		{fail_class_a, fail_class_b} = 2'h0;
		$display("test random levels done");
		{lvl.pwm, lvl.en, drv.pwm} = 3'b110;
		tick(4);
		check("pwm_float", 1'b0, pwm_link_cmd);
		{drv.pwm, drv.en} = 2'b10;
		tick(4);
		check("en_float", 1'b0, pwm_link_cmd);
		{drv.en, lvl.pwm, lvl.stp} = 3'b101;
		tick(4);
		lvl.pwm = 1'b1;
		tick(4);
		check("stp_high", 1'b0, pwm_link_cmd);
		lvl.pwm = 1'b0;
		lvl.stp = 1'b0;
		tick(3);
		lvl.pwm = 1'b1;
		tick(4);
		check("stp_dead", 1'b0, pwm_link_cmd);
		lvl.pwm = 1'b0;
		tick(DC + 6);
		lvl.pwm = 1'b1;
		tick(4);
		check("stp_after", 1'b1, pwm_link_cmd);
		lvl.stp = 1'b1;
		tick(DC);
		check("stp_keep_on", 1'b1, pwm_link_cmd);
		{lvl.pwm, drv.stp} = 2'b00;
		tick(DC + 4);
		lvl.pwm = 1'b1;
		tick(4);
		check("stp_float", 1'b1, pwm_link_cmd);
		{lvl.stp, drv.stp} = 2'b01;
		$display("test pwm path done");
		{sclk_in, sdi_in, chip_select_n} = 3'h0;
		{sclk_in_valid, sdi_in_valid, cs_in_valid} = 3'h0;
		tick(4);
		check("sclk_float", 1'b1, spi_sclk);
		check("sdi_float", 1'b1, spi_sdi);
		check("cs_float", 1'b1, spi_cs_n);
		{sclk_in_valid, sdi_in_valid, cs_in_valid} = 3'h7;
		tick(4);
		check("cs_select", 1'b0, spi_cs_n);
		{dio_out_mode, dio_out_val} = 2'b11;
		tick(3);
		check("dio_oe", 1'b0, primary_digital_channel_oe_n);
		check("dio_out", 1'b1, primary_digital_channel_o);
		{dio_out_mode, dio_hv, dio_h} = 3'b001;
		tick(4);
		check("dio_in_oe", 1'b1, primary_digital_channel_oe_n);
		check("dio_float", 1'b0, dio_rx);
		{dio_hv, dio_h} = 2'b11;
		tick(4);
		check("dio_in", 1'b1, dio_rx);
		$display("test spi and dio done");
		drv.trig = 1'b0;
		n_pulse = 0;
		tick(8);
		check("trig_float", 1'b1, n_pulse == 0);
		drv.trig = 1'b1;
		tick(4);
		n_pulse = 0;
		lvl.trig = 1'b1;
		tick(8);
		check("trig_pulse", 1'b1, n_pulse == 1);
		n_srst = 0;
		lvl.rst_n = 1'b0;
		tick(RST_VALID_CYCLES + 6);
		lvl.rst_n = 1'b1;
		tick(4);
		check("soft_reset", 1'b1, n_srst > 0);
		wait_rdy();
		chip_functional = 1'b0;
		tick(3);
		check("not_ready", 1'b0, reset_ready_oe_n);
		check("rdy_lvl", 1'b0, reset_in_ready_out_n);
		$display("test trigger and reset pin done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
